// ==== twba_arbiter.sv ====
// file: two-wire bus ownership state machine with bus lock
`timescale 1ns/1ps
module twba_arbiter (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  input  wire logic                        wdog_reset,
  input  wire logic                        bus_grant_n,
  input  wire logic                        bus_lock_flag,
  input  wire twba_pkg::twba_core_req_type core_req,
  input  wire logic                        cycle_end,
  output logic                             core_start_q,
  output logic                             bus_driven_n,
  output logic                             transfer_start_n,
  output logic                             bus_oe_n,
  output logic                             bus_owned_q
);

  ////////////////////////////////////////////////////////////////////////////
  // grant pin synchronisation

  logic grant_lvl;   // synchronised pin level, low = granted
  logic granted;

  twba_sync u_grant_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  (bus_grant_n),
    .level_q (grant_lvl)
  );

  assign granted = !grant_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // state

  twba_pkg::twba_state_type state_q;
  twba_pkg::twba_state_type state_d;
  twba_pkg::twba_drive_type drv_q;
  twba_pkg::twba_drive_type drv_d;
  logic                     in_prog_q;
  logic                     in_prog_d;
  logic                     start_now;
  logic                     end_of_series;

  // a series only ends on the terminating transfer of the access
  assign end_of_series = cycle_end && !core_req.burst_more;

  // in explicit ownership a new access may start only with no access under way
  function automatic logic can_start(input logic req, input logic busy);
    can_start = req && !busy;
  endfunction : can_start

  always_comb begin
    state_d   = state_q;
    start_now = 1'b0;
    case (state_q)
      twba_pkg::ST_RESET: begin
        state_d = granted ? twba_pkg::ST_IMPL_OWN : twba_pkg::ST_EM_OWN;
      end
      twba_pkg::ST_EM_OWN, twba_pkg::ST_IMPL_OWN: begin
        if (!granted) begin
          state_d = twba_pkg::ST_EM_OWN;
        end else if (bus_lock_flag || core_req.req) begin
          state_d   = twba_pkg::ST_EXPL_OWN;
          start_now = core_req.req;
        end else begin
          state_d = twba_pkg::ST_IMPL_OWN;
        end
      end
      twba_pkg::ST_EXPL_OWN: begin
        start_now = can_start(core_req.req, in_prog_q);
        if (granted || bus_lock_flag) begin
          state_d = twba_pkg::ST_EXPL_OWN;
        end else if (!in_prog_q) begin
          state_d   = twba_pkg::ST_EM_OWN;
          start_now = 1'b0;
        end else if (end_of_series) begin
          state_d   = twba_pkg::ST_EM_OWN;
          start_now = 1'b0;
        end
      end
      default: begin
        state_d = twba_pkg::ST_RESET;
      end
    endcase
  end

  // in-progress tracking: start wins over end in the same clock
  always_comb begin
    in_prog_d = in_prog_q;
    if (start_now) begin
      in_prog_d = 1'b1;
    end else if (end_of_series) begin
      in_prog_d = 1'b0;
    end
  end

  always_comb begin
    drv_d.bd_n     = (state_d == twba_pkg::ST_EXPL_OWN) ? 1'b0 : 1'b1;
    drv_d.bus_oe_n = drv_d.bd_n;
    drv_d.ts_n     = !start_now;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || wdog_reset) begin
      state_q <= twba_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || wdog_reset) begin
      in_prog_q <= 1'b0;
    end else begin
      in_prog_q <= in_prog_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  // bus-side drive levels; every pin level leaves straight from a flop
  always_ff @(posedge ref_clk) begin
    if (!rst_b || wdog_reset) begin
      drv_q.bd_n     <= twba_pkg::BD_RESET_LVL;
      drv_q.bus_oe_n <= twba_pkg::BD_RESET_LVL;
      drv_q.ts_n     <= twba_pkg::TS_RESET_LVL;
    end else begin
      drv_q <= drv_d;
    end
  end

  // start pulse for the core, in step with transfer start
  always_ff @(posedge ref_clk) begin
    if (!rst_b || wdog_reset) begin
      core_start_q <= 1'b0;
    end else begin
      core_start_q <= start_now;
    end
  end

  // owned includes implicit, so it differs from bus-driven while idle
  always_ff @(posedge ref_clk) begin
    if (!rst_b || wdog_reset) begin
      bus_owned_q <= 1'b0;
    end else begin
      bus_owned_q <= (state_d == twba_pkg::ST_EXPL_OWN) ||
                     (state_d == twba_pkg::ST_IMPL_OWN);
    end
  end

  assign bus_driven_n     = drv_q.bd_n;
  assign transfer_start_n = drv_q.ts_n;
  assign bus_oe_n         = drv_q.bus_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || wdog_reset);

  a_ts_needs_bd: assert property (
    !transfer_start_n |-> !bus_driven_n)
    else $error("transfer start without bus-driven");

  a_oe_tracks_bd: assert property (
    bus_oe_n == bus_driven_n)
    else $error("bus drive and bus-driven disagree");

  a_impl_undriven: assert property (
    state_q == twba_pkg::ST_IMPL_OWN |-> bus_driven_n && bus_oe_n)
    else $error("bus driven in implicit ownership");

  a_lock_takes_bus: assert property (
    state_q == twba_pkg::ST_IMPL_OWN && granted && bus_lock_flag |=> !bus_driven_n)
    else $error("lock did not take bus next clock");

  a_req_starts: assert property (
    state_q == twba_pkg::ST_IMPL_OWN && granted && core_req.req
    |=> !bus_driven_n && !transfer_start_n)
    else $error("request did not start access with bus-driven");

  a_lock_only_no_ts: assert property (
    state_q == twba_pkg::ST_IMPL_OWN && granted && bus_lock_flag && !core_req.req
    |=> transfer_start_n)
    else $error("transfer start on lock-only entry");

  a_granted_held: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && granted |=> !bus_driven_n)
    else $error("bus-driven dropped while granted");

  a_locked_held: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && bus_lock_flag |=> !bus_driven_n)
    else $error("bus-driven dropped while locked");

  a_cycle_kept: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && in_prog_q && !end_of_series |=> !bus_driven_n)
    else $error("bus released mid series");

  a_unlock_release: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && !granted && !bus_lock_flag && !in_prog_q
    |=> bus_driven_n && bus_oe_n)
    else $error("bus not released after unlock");

  a_em_undriven: assert property (
    state_q == twba_pkg::ST_EM_OWN |-> bus_driven_n)
    else $error("bus-driven in external ownership");

  a_em_no_start: assert property (
    state_q == twba_pkg::ST_EM_OWN |-> transfer_start_n && bus_oe_n)
    else $error("bus driven or started in external ownership");

  // five steady pin samples always reach the synchronised grant
  a_grant_low: assert property (
    (!bus_grant_n) [*5] |-> granted)
    else $error("grant pin low but bus not seen as granted");

  a_grant_high: assert property (
    bus_grant_n [*5] |-> !granted)
    else $error("grant pin high but bus still seen as granted");

  a_grant_start: assert property (
    (state_q == twba_pkg::ST_EM_OWN || state_q == twba_pkg::ST_IMPL_OWN) &&
    granted && core_req.req |=> !transfer_start_n && core_start_q)
    else $error("granted request did not start next clock");

  a_ts_single: assert property (
    !transfer_start_n |=> transfer_start_n)
    else $error("transfer start held longer than one clock");

  a_busy_no_start: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && in_prog_q |=> transfer_start_n)
    else $error("new start while an access is in progress");

  a_end_release: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && in_prog_q && end_of_series && !granted &&
    !bus_lock_flag |=> bus_driven_n)
    else $error("bus-driven kept after last transfer");

  a_release_quiet: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && in_prog_q && end_of_series && !granted &&
    !bus_lock_flag |=> bus_oe_n && transfer_start_n && !bus_owned_q)
    else $error("bus not tri-stated after release");

  // lock clear acts at the very next edge, with no filtering
  a_lock_sampled: assert property (
    state_q == twba_pkg::ST_EXPL_OWN && !granted && !bus_lock_flag && !in_prog_q
    |=> !bus_owned_q)
    else $error("lock clear not acted on next clock");

  a_state_onehot: assert property (
    $onehot(state_q))
    else $error("ownership state not one-hot");

  // the reset-state check names its own disable so it can watch reset itself
  a_reset_state: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !rst_b || wdog_reset |=> state_q == twba_pkg::ST_RESET && bus_driven_n &&
    bus_oe_n && transfer_start_n && !bus_owned_q && !core_start_q)
    else $error("outputs not quiet after reset");

  a_reset_to_impl: assert property (
    state_q == twba_pkg::ST_RESET && granted |=> state_q == twba_pkg::ST_IMPL_OWN)
    else $error("reset exit ignored asserted grant");

  a_reset_to_em: assert property (
    state_q == twba_pkg::ST_RESET && !granted |=> state_q == twba_pkg::ST_EM_OWN)
    else $error("reset exit ignored negated grant");

  c_lock_hold: cover property (
    state_q == twba_pkg::ST_EXPL_OWN && !granted && bus_lock_flag);
  c_req_entry: cover property (
    state_q == twba_pkg::ST_IMPL_OWN ##1 !transfer_start_n);
  c_series_release: cover property (
    state_q == twba_pkg::ST_EXPL_OWN && end_of_series && !granted ##1
    state_q == twba_pkg::ST_EM_OWN);
  c_lock_release: cover property (
    state_q == twba_pkg::ST_EXPL_OWN && !granted && !bus_lock_flag ##1
    state_q == twba_pkg::ST_EM_OWN);
  c_burst_hold: cover property (
    state_q == twba_pkg::ST_EXPL_OWN && !granted && cycle_end && core_req.burst_more);

endmodule : twba_arbiter

// ==== twba_pkg.sv ====
// package: shared states, carriers and constants for the two-wire bus arbiter
package twba_pkg;

  // ownership states, one-hot
  typedef enum logic [3:0] {
    ST_RESET    = 4'b0001,
    ST_EM_OWN   = 4'b0010,
    ST_IMPL_OWN = 4'b0100,
    ST_EXPL_OWN = 4'b1000
  } twba_state_type;

  localparam int unsigned SYNC_STAGES = 3;
  localparam logic        GRANT_IDLE_LVL = 1'b1;   // grant pin level at reset: negated
  localparam logic        BD_RESET_LVL   = 1'b1;   // bus-driven at reset: negated
  localparam logic        TS_RESET_LVL   = 1'b1;   // transfer start at reset: negated

  // core request side, same clock
  typedef struct packed {
    logic req;        // internal bus request pending
    logic burst_more; // more transfers of the same access follow
  } twba_core_req_type;

  // bus-side drive controls
  typedef struct packed {
    logic bus_oe_n;   // low while address/data/control are driven
    logic bd_n;       // bus-driven output level
    logic ts_n;       // transfer start output level
  } twba_drive_type;

endpackage : twba_pkg

// ==== twba_sync.sv ====
// file: three-stage synchroniser for the grant pin
`timescale 1ns/1ps
module twba_sync (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_q <= twba_pkg::GRANT_IDLE_LVL;
      s2_q <= twba_pkg::GRANT_IDLE_LVL;
      s3_q <= twba_pkg::GRANT_IDLE_LVL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change accepted only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level_q <= twba_pkg::GRANT_IDLE_LVL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule : twba_sync

// ==== twba_ext_master.sv ====
// file: behavioural external master on the hold-request side of the pins
`timescale 1ns/1ps
module twba_ext_master (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       need_bus,
  input  wire logic [3:0] finish_dly,
  input  wire logic       bus_driven_n,
  output logic            master_hold_request,
  output logic            master_hold_acknowledge,
  output logic            em_driving
);
  logic [3:0] left_q;
  // straight wire: low bus-driven reads as acknowledge negated
  assign master_hold_acknowledge = bus_driven_n;
  assign em_driving = master_hold_request & master_hold_acknowledge
                    & (need_bus | (left_q != 4'h0));
  ////////////////////////////////////////////////////////////////////////
  // own transfer winds down before the grant is handed over
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      master_hold_request <= 1'b1;
      left_q              <= 4'h0;
    end else if (need_bus) begin
      master_hold_request <= 1'b1;
      left_q              <= finish_dly;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end else begin
      master_hold_request <= 1'b0;
    end
  end
endmodule : twba_ext_master

// ==== twba_arbiter_tb.sv ====
// file: self-checking bench for the two-wire bus arbiter
`timescale 1ns/1ps
module twba_arbiter_tb;
  logic                        ref_clk = 0, rst_b = 0, wdog = 0, lock = 0;
  logic                        cend = 0, need = 1;
  logic [3:0]                  fdly = 4'h0;
  twba_pkg::twba_core_req_type creq = '0;
  logic                        cs, bd_n, ts_n, oe_n, own, hreq, hack, emd, bd_prev;
  logic                        exp_q[$];
  int                          fail_count = 0, n_compared = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  twba_arbiter twba_arbiter_i (.ref_clk(ref_clk), .rst_b(rst_b), .wdog_reset(wdog),
    .bus_grant_n(hreq), .bus_lock_flag(lock), .core_req(creq), .cycle_end(cend),
    .core_start_q(cs), .bus_driven_n(bd_n), .transfer_start_n(ts_n),
    .bus_oe_n(oe_n), .bus_owned_q(own));
  twba_ext_master twba_ext_master_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .need_bus(need), .finish_dly(fdly), .bus_driven_n(bd_n),
    .master_hold_request(hreq), .master_hold_acknowledge(hack), .em_driving(emd));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : clk
  // bounded wait on owned (0), bus-driven (1) or start pulse (2)
  task automatic wait_on(input int sel, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if ((sel == 0 ? own : sel == 1 ? bd_n : cs) === v) break;
      @(posedge ref_clk);
    end
    chk(i < n, 1'b1);
  endtask : wait_on
  task automatic start_access();
    creq.req <= 1'b1;
    if (bd_n) exp_q.push_back(1'b0);
    wait_on(2, 1'b1, 20);
    chk(ts_n, 1'b0);
    creq.req <= 1'b0;
    clk(1);
    chk(ts_n, 1'b1);
  endtask : start_access
  task automatic end_xfer(input logic more);
    cend <= 1'b1;
    creq.burst_more <= more;
    clk(1);
    cend <= 1'b0;
    creq.burst_more <= 1'b0;
    clk(1);
  endtask : end_xfer
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  // watcher: every bus-driven change takes the oldest note
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      fail_count++;
      report_and_stop();
    end else begin
      bd_prev <= bd_n;
      if (rst_b && !wdog) begin
        chk(oe_n, bd_n);
        chk(emd & ~oe_n, 1'b0);
        if (bd_n !== bd_prev) chk(bd_n, exp_q.size() ? exp_q.pop_front() : ~bd_n);
      end
    end
  end
  initial begin
    void'($urandom(32'h4846));
    clk(20);
    rst_b <= 1'b1;
    creq.req <= 1'b1;
    clk(10);
    chk(cs, 1'b0);
    chk(own, 1'b0);
    fdly <= 4'($urandom_range(7));
    need <= 1'b0;
    start_access();
    $display("test grant_start done");
    // grant pulled during a burst-inhibited series
    need <= 1'b1;
    end_xfer(1'b1);
    clk(8);
    end_xfer(1'b1);
    chk(bd_n, 1'b0);
    exp_q.push_back(1'b1);
    end_xfer(1'b0);
    wait_on(1, 1'b1, 3);
    $display("test burst_release done");
    need <= 1'b0;
    wait_on(0, 1'b1, 24);
    clk(2);
    chk(bd_n, 1'b1);
    lock <= 1'b1;
    exp_q.push_back(1'b0);
    wait_on(1, 1'b0, 3);
    chk(ts_n, 1'b1);
    need <= 1'b1;
    clk(10);
    chk(bd_n, 1'b0);
    lock <= 1'b0;
    exp_q.push_back(1'b1);
    wait_on(1, 1'b1, 3);
    $display("test lock done");
    need <= 1'b0;
    wait_on(0, 1'b1, 24);
    clk(2);
    repeat (3) begin
      start_access();
      clk($urandom_range(4, 1));
      end_xfer(1'b0);
    end
    clk(5);
    chk(bd_n, 1'b0);
    exp_q.push_back(1'b1);
    wdog <= 1'b1;
    clk(1);
    wdog <= 1'b0;
    wait_on(1, 1'b1, 3);
    clk(4);
    chk(exp_q.size() == 0, 1'b1);
    $display("test idle_and_watchdog done");
    report_and_stop();
  end
endmodule : twba_arbiter_tb
